// [logic/iwd_pkg.sv]
// Package of encodings, field positions and timing for the instruction word decoder
package iwd_pkg;
  localparam int unsigned INSN_W       = 14;
  localparam int unsigned FADDR_W      = 7;
  localparam int unsigned BIDX_W       = 3;
  localparam int unsigned PC_W         = 13;
  localparam int unsigned LIT11_W      = 11;
  localparam int unsigned FADDR_LSB    = 0;
  localparam int unsigned DEST_POS     = 7;
  localparam int unsigned BIDX_LSB     = 7;
  localparam int unsigned BYTE_OP_LSB  = 8;
  localparam int unsigned BIT_OP_LSB   = 10;
  localparam int unsigned CLASS_LSB    = 12;
  localparam int unsigned GOTO_POS     = 11;
  localparam int unsigned LIT_OP_LSB   = 8;
  localparam int unsigned LATCH_LSB    = 3;
  localparam int unsigned OSC_PER_CYC  = 4;
  localparam int unsigned OSC_FREQ_MHZ = 4;
  // Nanoseconds per instruction cycle at the reference oscillator
  localparam int unsigned CYC_TIME_NS  = OSC_PER_CYC * 1000 / OSC_FREQ_MHZ;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PHASE_W      = 2;

  localparam logic [1:0] CLASS_BYTE = 2'h0;
  localparam logic [1:0] CLASS_BIT  = 2'h1;
  localparam logic [1:0] CLASS_CTRL = 2'h2;
  localparam logic [1:0] CLASS_LIT  = 2'h3;

  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_A_ADDR     = 7'h05;
  localparam logic [6:0] INDF_ADDR       = 7'h00;
  localparam logic [PC_W-1:0] PC_RST     = 13'h0000;
  localparam logic [7:0] W_RST           = 8'h00;

  typedef enum logic [4:0] {
    IWD_NOP, IWD_MOVWF, IWD_CLRW, IWD_CLEAR_FILE_OP, IWD_SUBWF, IWD_DECF, IWD_IORWF,
    IWD_ANDWF, IWD_XORWF, IWD_ADDWF, IWD_MOVF, IWD_COMF, IWD_INCF, IWD_DECFSZ,
    IWD_RRF, IWD_RLF, IWD_SWAPF, IWD_INCFSZ, IWD_BCF, IWD_BSF, IWD_BTFSC,
    IWD_BTFSS, IWD_CALL, IWD_GOTO, IWD_MOVLW, IWD_RETLW, IWD_IORLW, IWD_ANDLW,
    IWD_XORLW, IWD_SUBLW, IWD_ADDLW, IWD_RET
  } iwd_op_e;

  typedef enum logic [1:0] {
    IWD_Q1, IWD_Q2, IWD_Q3, IWD_Q4
  } iwd_phase_e;
endpackage

// [logic/iwd_field_split.sv]
// Combinational split of an instruction word into its operation and operand fields
module iwd_field_split (
  input  wire logic [13:0] i_word,
  output iwd_pkg::iwd_op_e  o_op,
  output logic [6:0]        o_faddr,
  output logic              o_dest_file,
  output logic [2:0]        o_bit_idx,
  output logic [7:0]        o_lit8,
  output logic [10:0]       o_lit11,
  output logic              o_uses_file
);
  logic [1:0] cls;
  logic [3:0] bop;
  logic [1:0] tbop;
  logic [3:0] lop;

  always_comb begin
    cls         = i_word[iwd_pkg::CLASS_LSB +: 2];
    bop         = i_word[iwd_pkg::BYTE_OP_LSB +: 4];
    tbop        = i_word[iwd_pkg::BIT_OP_LSB +: 2];
    lop         = i_word[iwd_pkg::LIT_OP_LSB +: 4];
    o_faddr     = i_word[iwd_pkg::FADDR_LSB +: iwd_pkg::FADDR_W];
    o_dest_file = i_word[iwd_pkg::DEST_POS];
    o_bit_idx   = i_word[iwd_pkg::BIDX_LSB +: iwd_pkg::BIDX_W];
    o_lit8      = i_word[7:0];
    o_lit11     = i_word[iwd_pkg::LIT11_W-1:0];
    o_op        = iwd_pkg::IWD_NOP;
    unique case (cls)
      iwd_pkg::CLASS_BYTE: begin
        unique case (bop)
          4'h0: begin
            if (o_dest_file) begin
              o_op = iwd_pkg::IWD_MOVWF;
            end else if (i_word[6:0] == 7'h08 || i_word[6:0] == 7'h09) begin
              o_op = iwd_pkg::IWD_RET;
            end else begin
              // Sleep and watchdog clear are outside this block; treated as no-ops
              o_op = iwd_pkg::IWD_NOP;
            end
          end
          4'h1: o_op = o_dest_file ? iwd_pkg::IWD_CLEAR_FILE_OP : iwd_pkg::IWD_CLRW; // [RULE_13]
          4'h2: o_op = iwd_pkg::IWD_SUBWF;
          4'h3: o_op = iwd_pkg::IWD_DECF;
          4'h4: o_op = iwd_pkg::IWD_IORWF;
          4'h5: o_op = iwd_pkg::IWD_ANDWF;
          4'h6: o_op = iwd_pkg::IWD_XORWF;
          4'h7: o_op = iwd_pkg::IWD_ADDWF;
          4'h8: o_op = iwd_pkg::IWD_MOVF;
          4'h9: o_op = iwd_pkg::IWD_COMF;
          4'ha: o_op = iwd_pkg::IWD_INCF;
          4'hb: o_op = iwd_pkg::IWD_DECFSZ;
          4'hc: o_op = iwd_pkg::IWD_RRF;
          4'hd: o_op = iwd_pkg::IWD_RLF;
          4'he: o_op = iwd_pkg::IWD_SWAPF;
          4'hf: o_op = iwd_pkg::IWD_INCFSZ;
        endcase
      end
      iwd_pkg::CLASS_BIT: begin
        unique case (tbop)
          2'h0: o_op = iwd_pkg::IWD_BCF;
          2'h1: o_op = iwd_pkg::IWD_BSF;
          2'h2: o_op = iwd_pkg::IWD_BTFSC;
          2'h3: o_op = iwd_pkg::IWD_BTFSS;
        endcase
      end
      iwd_pkg::CLASS_CTRL: begin
        o_op = i_word[iwd_pkg::GOTO_POS] ? iwd_pkg::IWD_GOTO : iwd_pkg::IWD_CALL;
      end
      iwd_pkg::CLASS_LIT: begin
        // Don't-care bits are never compared, so either value decodes alike
        unique casez (lop) // [RULE_13]
          4'b00??: o_op = iwd_pkg::IWD_MOVLW;
          4'b01??: o_op = iwd_pkg::IWD_RETLW;
          4'b1000: o_op = iwd_pkg::IWD_IORLW;
          4'b1001: o_op = iwd_pkg::IWD_ANDLW;
          4'b1010: o_op = iwd_pkg::IWD_XORLW;
          4'b1011: o_op = iwd_pkg::IWD_XORLW;
          4'b110?: o_op = iwd_pkg::IWD_SUBLW;
          4'b111?: o_op = iwd_pkg::IWD_ADDLW;
        endcase
      end
    endcase
    o_uses_file = (cls == iwd_pkg::CLASS_BIT) ||
                  (cls == iwd_pkg::CLASS_BYTE && o_op != iwd_pkg::IWD_NOP &&
                   o_op != iwd_pkg::IWD_CLRW && o_op != iwd_pkg::IWD_RET);
  end
endmodule

// [logic/iwd_core.sv]
// Instruction decode, quarter-cycle sequencing and read-modify-write core
// Summary of operation
// RULE_01: Every instruction is one 14-bit word of opcode and operand fields.
// RULE_02: Byte operation with destination zero writes the working register only.
// RULE_03: Byte operation with destination one writes the addressed file register.
// RULE_04: File address field is seven bits, reaching 0x00 to 0x7F.
// RULE_05: Bit operations pick one bit of the addressed byte by index.
// RULE_06: Literal operations use an 8-bit or an 11-bit constant.
// RULE_07: One instruction cycle spans four oscillator periods.
// RULE_08: One cycle per instruction, two when skipping or changing the program counter.
// RULE_09: The second cycle of a two-cycle instruction executes as a no-operation.
// RULE_10: File instructions read, modify, then store to the chosen destination.
// RULE_11: The read happens even when the instruction only writes.
// RULE_12: Read side effects, like clearing port change, occur on every such read.
// RULE_13: Don't-care encoding bits are ignored whatever their value.
// RULE_14: Port reads in read-modify-write take pin levels, not the output latch.
// RULE_15: Call pushes return address, loads 11-bit literal plus two latch bits.
// RULE_16: Writing the timer-zero register clears its prescaler when assigned there.
// RULE_17: Destination bit sits directly above the seven-bit file address.
module iwd_core (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [13:0] i_insn_word,
  input  wire logic [7:0]  i_file_rdata,
  input  wire logic [7:0]  i_port_a_pins,
  input  wire logic [1:0]  i_program_counter_upper_latch,
  input  wire logic [12:0] i_stack_top,
  input  wire logic        i_prescaler_on_timer,
  output logic [12:0]      o_prog_addr,
  output logic             o_insn_fetch,
  output logic [6:0]       o_file_addr,
  output logic             o_file_rd,
  output logic             o_file_wr,
  output logic [7:0]       o_file_wdata,
  output logic             o_port_change_clear,
  output logic             o_prescaler_clear,
  output logic             o_stack_push,
  output logic             o_stack_pop,
  output logic [12:0]      o_stack_push_data,
  output logic [7:0]       o_w_reg,
  output logic             o_zero_flag,
  output logic             o_carry_flag,
  output logic             o_digit_carry_flag,
  output logic [1:0]       o_phase,
  output logic             o_flush_cycle
);
  logic              rst_s1_q;
  logic              rst_s2_q;
  logic              rst_n;
  iwd_pkg::iwd_phase_e phase_q, phase_d;
  logic [12:0]       pc_q, pc_d;
  logic [13:0]       ir_q, ir_d;
  logic              flush_q, flush_d;
  logic [7:0]        opnd_q, opnd_d;
  logic [7:0]        w_q, w_d;
  logic              z_q, z_d, c_q, c_d, digit_carry_q, digit_carry_d;
  logic [6:0]        fa_q, fa_d;
  logic              rd_q, rd_d, wr_q, wr_d, pcc_q, pcc_d, psc_q, psc_d;
  logic              push_q, push_d, pop_q, pop_d;
  logic [7:0]        wdat_q, wdat_d;
  logic [12:0]       pdat_q, pdat_d;
  iwd_pkg::iwd_op_e  op;
  logic [6:0]        faddr;
  logic              dest_file;
  logic [2:0]        bidx;
  logic [7:0]        lit8;
  logic [10:0]       lit11;
  logic              uses_file;
  logic [8:0]        sum;
  logic [4:0]        nib;
  logic [7:0]        res;
  logic              to_w;
  logic              to_f;
  logic              skip;
  logic              setz;

  // Reset release through two stages so the core leaves reset on a clean edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  iwd_field_split u_split (
    .i_word      (ir_q),
    .o_op        (op),
    .o_faddr     (faddr),       // [RULE_04]
    .o_dest_file (dest_file),   // [RULE_17]
    .o_bit_idx   (bidx),
    .o_lit8      (lit8),
    .o_lit11     (lit11),
    .o_uses_file (uses_file)
  );

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  always_comb begin
    phase_d = phase_q;
    pc_d    = pc_q;
    ir_d    = ir_q;
    flush_d = flush_q;
    opnd_d  = opnd_q;
    w_d     = w_q;
    z_d     = z_q;
    c_d     = c_q;
    digit_carry_d = digit_carry_q;
    fa_d    = faddr;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    pcc_d   = 1'b0;
    psc_d   = 1'b0;
    push_d  = 1'b0;
    pop_d   = 1'b0;
    wdat_d  = wdat_q;
    pdat_d  = pdat_q;
    sum     = 9'h000;
    nib     = 5'h00;
    res     = 8'h00;
    to_w    = 1'b0;
    to_f    = 1'b0;
    skip    = 1'b0;
    setz    = 1'b0;
    // Four clock periods make one instruction cycle
    unique case (phase_q) // [RULE_07]
      iwd_pkg::IWD_Q1: phase_d = iwd_pkg::IWD_Q2;
      iwd_pkg::IWD_Q2: phase_d = iwd_pkg::IWD_Q3;
      iwd_pkg::IWD_Q3: phase_d = iwd_pkg::IWD_Q4;
      iwd_pkg::IWD_Q4: phase_d = iwd_pkg::IWD_Q1;
    endcase
    // Q2: read every named file register, even for pure writes
    if (phase_q == iwd_pkg::IWD_Q1 && !flush_q && uses_file) begin
      rd_d  = 1'b1; // [RULE_10] [RULE_11]
      pcc_d = (faddr == iwd_pkg::PORT_A_ADDR); // [RULE_12]
    end
    if (phase_q == iwd_pkg::IWD_Q2 && !flush_q && uses_file) begin
      // Port data comes from the pins, so inputs overwrite latch state on write-back
      opnd_d = (faddr == iwd_pkg::PORT_A_ADDR) ? i_port_a_pins : i_file_rdata; // [RULE_14]
    end
    if (phase_q == iwd_pkg::IWD_Q3) begin
      if (flush_q) begin
        flush_d = 1'b0; // [RULE_09]
      end else begin
        unique case (op)
          iwd_pkg::IWD_MOVWF:  begin res = w_q; to_f = 1'b1; end
          iwd_pkg::IWD_CLRW:   begin res = 8'h00; to_w = 1'b1; setz = 1'b1; end
          iwd_pkg::IWD_CLEAR_FILE_OP: begin res = 8'h00; to_f = 1'b1; setz = 1'b1; end // [RULE_11]
          iwd_pkg::IWD_SUBWF, iwd_pkg::IWD_SUBLW: begin
            sum  = {1'b0, (op == iwd_pkg::IWD_SUBLW) ? lit8 : opnd_q} + {1'b0, ~w_q} + 9'h001;
            nib  = {1'b0, ((op == iwd_pkg::IWD_SUBLW) ? lit8[3:0] : opnd_q[3:0])}
                   + {1'b0, ~w_q[3:0]} + 5'h01;
            res  = sum[7:0]; c_d = sum[8]; digit_carry_d = nib[4]; setz = 1'b1;
          end
          iwd_pkg::IWD_ADDWF, iwd_pkg::IWD_ADDLW: begin
            sum  = {1'b0, (op == iwd_pkg::IWD_ADDLW) ? lit8 : opnd_q} + {1'b0, w_q};
            nib  = {1'b0, ((op == iwd_pkg::IWD_ADDLW) ? lit8[3:0] : opnd_q[3:0])}
                   + {1'b0, w_q[3:0]};
            res  = sum[7:0]; c_d = sum[8]; digit_carry_d = nib[4]; setz = 1'b1;
          end
          iwd_pkg::IWD_DECF:   begin res = opnd_q - 8'h01; setz = 1'b1; end
          iwd_pkg::IWD_IORWF:  begin res = opnd_q | w_q; setz = 1'b1; end
          iwd_pkg::IWD_ANDWF:  begin res = opnd_q & w_q; setz = 1'b1; end
          iwd_pkg::IWD_XORWF:  begin res = opnd_q ^ w_q; setz = 1'b1; end
          iwd_pkg::IWD_MOVF:   begin res = opnd_q; setz = 1'b1; end
          iwd_pkg::IWD_COMF:   begin res = ~opnd_q; setz = 1'b1; end
          iwd_pkg::IWD_INCF:   begin res = opnd_q + 8'h01; setz = 1'b1; end
          iwd_pkg::IWD_DECFSZ: begin res = opnd_q - 8'h01; skip = (res == 8'h00); end
          iwd_pkg::IWD_INCFSZ: begin res = opnd_q + 8'h01; skip = (res == 8'h00); end
          iwd_pkg::IWD_RRF:    begin res = {c_q, opnd_q[7:1]}; c_d = opnd_q[0]; end
          iwd_pkg::IWD_RLF:    begin res = {opnd_q[6:0], c_q}; c_d = opnd_q[7]; end
          iwd_pkg::IWD_SWAPF:  res = {opnd_q[3:0], opnd_q[7:4]};
          iwd_pkg::IWD_BCF:    begin res = opnd_q & ~bit_mask(bidx); to_f = 1'b1; end // [RULE_05]
          iwd_pkg::IWD_BSF:    begin res = opnd_q | bit_mask(bidx); to_f = 1'b1; end // [RULE_05]
          iwd_pkg::IWD_BTFSC:  skip = ((opnd_q & bit_mask(bidx)) == 8'h00); // [RULE_05]
          iwd_pkg::IWD_BTFSS:  skip = ((opnd_q & bit_mask(bidx)) != 8'h00);
          iwd_pkg::IWD_MOVLW:  begin res = lit8; to_w = 1'b1; end // [RULE_06]
          iwd_pkg::IWD_RETLW:  begin w_d = lit8; pop_d = 1'b1; end
          iwd_pkg::IWD_IORLW:  begin res = lit8 | w_q; to_w = 1'b1; setz = 1'b1; end
          iwd_pkg::IWD_ANDLW:  begin res = lit8 & w_q; to_w = 1'b1; setz = 1'b1; end
          iwd_pkg::IWD_XORLW:  begin res = lit8 ^ w_q; to_w = 1'b1; setz = 1'b1; end
          iwd_pkg::IWD_RET:    pop_d = 1'b1;
          iwd_pkg::IWD_CALL:   begin push_d = 1'b1; pdat_d = pc_q; end // [RULE_15]
          default: ;
        endcase
        if (op inside {iwd_pkg::IWD_SUBLW, iwd_pkg::IWD_ADDLW}) to_w = 1'b1;
        if (op inside {iwd_pkg::IWD_SUBWF, iwd_pkg::IWD_ADDWF, iwd_pkg::IWD_DECF,
                       iwd_pkg::IWD_IORWF, iwd_pkg::IWD_ANDWF, iwd_pkg::IWD_XORWF,
                       iwd_pkg::IWD_MOVF, iwd_pkg::IWD_COMF, iwd_pkg::IWD_INCF,
                       iwd_pkg::IWD_DECFSZ, iwd_pkg::IWD_INCFSZ, iwd_pkg::IWD_RRF,
                       iwd_pkg::IWD_RLF, iwd_pkg::IWD_SWAPF}) begin
          to_f = dest_file;  // [RULE_03]
          to_w = !dest_file; // [RULE_02]
        end
        if (setz) z_d = (res == 8'h00);
        if (to_w) w_d = res; // [RULE_02]
        if (to_f) begin
          wr_d   = 1'b1; // [RULE_03] [RULE_10]
          wdat_d = res;
          psc_d  = (faddr == iwd_pkg::TIMER_ZERO_ADDR) && i_prescaler_on_timer; // [RULE_16]
        end
        // Taken skip or program-counter change costs one extra flushed cycle
        if (skip || op inside {iwd_pkg::IWD_CALL, iwd_pkg::IWD_GOTO,
                               iwd_pkg::IWD_RETLW, iwd_pkg::IWD_RET}) begin
          flush_d = 1'b1; // [RULE_08]
        end
        if (op inside {iwd_pkg::IWD_CALL, iwd_pkg::IWD_GOTO}) begin
          pc_d = {i_program_counter_upper_latch, lit11}; // [RULE_15] [RULE_06]
        end else if (op inside {iwd_pkg::IWD_RETLW, iwd_pkg::IWD_RET}) begin
          pc_d = i_stack_top;
        end
      end
    end
    // Q4: latch the next word; the flushed cycle still fetches but executes nothing
    if (phase_q == iwd_pkg::IWD_Q4) begin
      ir_d = flush_q ? 14'h0000 : i_insn_word; // [RULE_01] [RULE_09]
      // A jump has already loaded its target, so the discarded fetch must not step past it
      if (!(flush_q && op inside {iwd_pkg::IWD_CALL, iwd_pkg::IWD_GOTO,
                                  iwd_pkg::IWD_RETLW, iwd_pkg::IWD_RET})) begin
        pc_d = pc_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= iwd_pkg::IWD_Q1;
      pc_q    <= iwd_pkg::PC_RST;
      ir_q    <= 14'h0000;
      flush_q <= 1'b1;
      opnd_q  <= 8'h00;
      w_q     <= iwd_pkg::W_RST;
      z_q     <= 1'b0;
      c_q     <= 1'b0;
      digit_carry_q <= 1'b0;
      fa_q    <= 7'h00;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      pcc_q   <= 1'b0;
      psc_q   <= 1'b0;
      push_q  <= 1'b0;
      pop_q   <= 1'b0;
      wdat_q  <= 8'h00;
      pdat_q  <= 13'h0000;
    end else begin
      phase_q <= phase_d;
      pc_q    <= pc_d;
      ir_q    <= ir_d;
      flush_q <= flush_d;
      opnd_q  <= opnd_d;
      w_q     <= w_d;
      z_q     <= z_d;
      c_q     <= c_d;
      digit_carry_q <= digit_carry_d;
      fa_q    <= fa_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      pcc_q   <= pcc_d;
      psc_q   <= psc_d;
      push_q  <= push_d;
      pop_q   <= pop_d;
      wdat_q  <= wdat_d;
      pdat_q  <= pdat_d;
    end
  end

  assign o_prog_addr         = pc_q;
  assign o_insn_fetch        = (phase_q == iwd_pkg::IWD_Q4);
  assign o_file_addr         = fa_q;
  assign o_file_rd           = rd_q;
  assign o_file_wr           = wr_q;
  assign o_file_wdata        = wdat_q;
  assign o_port_change_clear = pcc_q;
  assign o_prescaler_clear   = psc_q;
  assign o_stack_push        = push_q;
  assign o_stack_pop         = pop_q;
  assign o_stack_push_data   = pdat_q;
  assign o_w_reg             = w_q;
  assign o_zero_flag         = z_q;
  assign o_carry_flag        = c_q;
  assign o_digit_carry_flag  = digit_carry_q;
  assign o_phase             = phase_q;
  assign o_flush_cycle       = flush_q;
endmodule

// [testbench/iwd_core_checker.sv]
// Port-level assertions for the instruction decoder core
module iwd_core_checker (
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic       i_prescaler_on_timer,
  input wire logic [6:0] o_file_addr,
  input wire logic       o_insn_fetch,
  input wire logic       o_file_rd,
  input wire logic       o_file_wr,
  input wire logic       o_port_change_clear,
  input wire logic       o_prescaler_clear,
  input wire logic       o_stack_push,
  input wire logic       o_stack_pop,
  input wire logic [7:0] o_w_reg,
  input wire logic [1:0] o_phase,
  input wire logic       o_flush_cycle
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_phase_seq;
    o_phase == 2'h1 |=> o_phase == 2'h2 ##1 o_phase == 2'h3 ##1 o_phase == 2'h0;
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("phase order broken");
  property p_fetch_q4;
    o_insn_fetch == (o_phase == 2'h3);
  endproperty
  a_fetch_q4: assert property (p_fetch_q4) else $error("fetch outside Q4");
  property p_rd_q2;
    o_file_rd |-> o_phase == 2'h1 && !o_flush_cycle;
  endproperty
  a_rd_q2: assert property (p_rd_q2) else $error("file read misplaced");
  property p_wr_after_rd;
    o_file_wr |-> $past(o_file_rd, 2) && o_file_addr == $past(o_file_addr, 2);
  endproperty
  a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without read");
  property p_port_clear;
    o_port_change_clear == (o_file_rd && o_file_addr == iwd_pkg::PORT_A_ADDR);
  endproperty
  a_port_clear: assert property (p_port_clear) else $error("port clear wrong");
  property p_presc;
    o_prescaler_clear == (o_file_wr && o_file_addr == iwd_pkg::TIMER_ZERO_ADDR
                          && i_prescaler_on_timer);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler clear wrong");
  property p_flush_quiet;
    o_flush_cycle && $past(o_flush_cycle) |-> !(o_file_rd || o_file_wr || o_stack_push ||
                                                o_stack_pop);
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("flush cycle active");
  property p_push_flush;
    o_stack_push |=> o_flush_cycle [*3];
  endproperty
  a_push_flush: assert property (p_push_flush) else $error("no flush after call");
  property p_wr_keeps_w;
    o_file_wr |-> $stable(o_w_reg);
  endproperty
  a_wr_keeps_w: assert property (p_wr_keeps_w) else $error("W changed on file write");
endmodule

bind iwd_core iwd_core_checker iwd_core_checker_inst (
  .i_core_clk, .i_rst_n, .i_prescaler_on_timer, .o_file_addr, .o_insn_fetch, .o_file_rd,
  .o_file_wr, .o_port_change_clear, .o_prescaler_clear, .o_stack_push, .o_stack_pop,
  .o_w_reg, .o_phase, .o_flush_cycle
);

// [testbench/iwd_prog_mem.sv]
// Program memory model feeding instruction words to the core
module iwd_prog_mem (
  input  wire logic [12:0] i_addr,
  input  wire logic        i_fetch,
  output logic [13:0]      o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] rom [8192];
  // Outside a fetch the bus shows the inverse, so an early or late sample is caught
  always_comb o_word = i_fetch ? rom[i_addr] : ~rom[i_addr];
endmodule

// [testbench/tb.sv]
// Self-checking bench: random program run against a reference model of the core
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b1;
  logic [13:0] i_insn_word;
  logic [7:0]  i_file_rdata = 8'h00;
  logic [7:0]  i_port_a_pins = 8'h00;
  logic [1:0]  i_program_counter_upper_latch = 2'h0;
  logic [12:0] i_stack_top = 13'h0000;
  logic        i_prescaler_on_timer = 1'b0;
  logic [12:0] o_prog_addr, o_stack_push_data, mpc;
  logic [6:0]  o_file_addr, addr_q;
  logic [7:0]  o_file_wdata, o_w_reg, mw, pins_q;
  logic [7:0]  fmem [128];
  logic [1:0]  o_phase;
  logic        o_insn_fetch, o_file_rd, o_file_wr, o_port_change_clear, o_prescaler_clear;
  logic        o_stack_push, o_stack_pop, o_zero_flag, o_carry_flag, o_digit_carry_flag;
  logic        o_flush_cycle, mc, mz, mdc, pend, rd_q, pcc_q;
  logic        run = 1'b0;
  logic [31:0] seed = 32'he4181f20;
  int          error_cnt = 0;
  int          comparisons = 0;

  iwd_prog_mem iwd_prog_mem_inst (.i_addr(o_prog_addr), .i_fetch(o_insn_fetch),
                                  .o_word(i_insn_word));
  iwd_core iwd_core_inst (.i_core_clk, .i_rst_n, .i_insn_word, .i_file_rdata, .i_port_a_pins,
    .i_program_counter_upper_latch, .i_stack_top, .i_prescaler_on_timer, .o_prog_addr,
    .o_insn_fetch, .o_file_addr, .o_file_rd, .o_file_wr, .o_file_wdata, .o_port_change_clear,
    .o_prescaler_clear, .o_stack_push, .o_stack_pop, .o_stack_push_data, .o_w_reg,
    .o_zero_flag, .o_carry_flag, .o_digit_carry_flag, .o_phase, .o_flush_cycle);

  always #5 i_core_clk = ~i_core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic mreset();
    mpc = 13'h0000;
    mw = iwd_pkg::W_RST;
    {mc, mz, mdc, pend} = 4'b0001;
  endtask

  // Reference model of one executed cycle, checked at Q4
  task automatic step();
    logic [13:0] w;
    logic [6:0]  fa;
    logic [7:0]  f, r;
    logic [12:0] ret;
    logic        erd, ewr, skip, push, pop, uz;
    if (pend) begin
      chk({o_flush_cycle, o_file_wr, rd_q}, 3'b000);
      pend = 1'b0;
      return;
    end
    w = iwd_prog_mem_inst.rom[mpc];
    mpc = mpc + 13'h1;
    ret = mpc;
    fa = w[6:0];
    f = (fa == iwd_pkg::PORT_A_ADDR) ? pins_q : fmem[fa];
    {erd, ewr, skip, push, pop, uz} = {2'b11, 4'h0};
    ewr = w[7];
    r = f;
    case (w[13:12])
      2'h0: begin
        uz = 1'b1;
        case (w[11:8])
          4'h0: begin
            {uz, r} = {1'b0, mw};
            if (!w[7]) begin
              erd = 1'b0;
              pop = (fa == 7'h08 || fa == 7'h09);
            end
          end
          4'h1: {erd, r} = {w[7], 8'h00};
          4'h2: {mc, mdc, r} = {f >= mw, f[3:0] >= mw[3:0], f - mw};
          4'h3: r = f - 8'h1;
          4'h4: r = f | mw;
          4'h5: r = f & mw;
          4'h6: r = f ^ mw;
          4'h7: begin
            mdc = ({1'b0, f[3:0]} + {1'b0, mw[3:0]}) > 5'h0f;
            {mc, r} = {1'b0, f} + {1'b0, mw};
          end
          4'h9: r = ~f;
          4'ha: r = f + 8'h1;
          4'hb: {uz, r, skip} = {1'b0, f - 8'h1, f == 8'h01};
          4'hc: {uz, r, mc} = {1'b0, mc, f};
          4'hd: {uz, mc, r} = {1'b0, f, mc};
          4'he: {uz, r} = {1'b0, f[3:0], f[7:4]};
          4'hf: {uz, r, skip} = {1'b0, f + 8'h1, f == 8'hff};
          default: r = f;
        endcase
      end
      2'h1: begin
        ewr = !w[11];
        r = w[10] ? (f | (8'h1 << w[9:7])) : (f & ~(8'h1 << w[9:7]));
        skip = w[11] && (f[w[9:7]] == w[10]);
      end
      2'h2: begin
        {erd, ewr, pend, push} = {3'b001, !w[11]};
        mpc = {i_program_counter_upper_latch, w[10:0]};
      end
      default: begin
        {erd, ewr, uz} = 3'b001;
        case (w[11:10])
          2'h0: {uz, mw} = {1'b0, w[7:0]};
          2'h1: {uz, mw, pop} = {1'b0, w[7:0], 1'b1};
          2'h2: mw = w[9] ? mw ^ w[7:0] : (w[8] ? mw & w[7:0] : mw | w[7:0]);
          default: begin
            mdc = w[9] ? (({1'b0, w[3:0]} + {1'b0, mw[3:0]}) > 5'h0f) : (w[3:0] >= mw[3:0]);
            {mc, mw} = w[9] ? {1'b0, w[7:0]} + {1'b0, mw}
                            : {w[7:0] >= mw, w[7:0] - mw};
          end
        endcase
        r = mw;
      end
    endcase
    if (pop) mpc = i_stack_top;
    if (skip) mpc = mpc + 13'h1;
    pend = pend | pop | skip;
    if (uz) mz = (r == 8'h00);
    if (ewr) fmem[fa] = r; else if (w[13:12] == 2'h0) mw = r;
    chk(o_flush_cycle, pend);
    chk(rd_q, erd);
    if (erd) chk(addr_q, fa);
    chk(pcc_q, erd && fa == iwd_pkg::PORT_A_ADDR);
    chk(o_file_wr, ewr);
    if (ewr) chk(o_file_wdata, r);
    chk(o_w_reg, mw);
    chk({o_zero_flag, o_carry_flag, o_digit_carry_flag}, {mz, mc, mdc});
    chk({o_stack_push, o_stack_pop}, {push, pop});
    if (push) chk(o_stack_push_data, ret);
    chk(o_prescaler_clear, ewr && fa == 7'h01 && i_prescaler_on_timer);
  endtask

  always @(negedge i_core_clk) begin
    if (run && o_phase == 2'h1) begin
      {rd_q, addr_q, pcc_q, pins_q} = {o_file_rd, o_file_addr, o_port_change_clear,
                                       i_port_a_pins};
    end
    if (run && o_phase == 2'h3) step();
  end

  // Slow-changing inputs move only at Q1 so they stand through every sampling point
  always @(posedge i_core_clk) begin
    #1;
    seed = lfsr(seed);
    i_port_a_pins = seed[7:0];
    i_file_rdata = fmem[o_file_addr];
    if (o_phase == 2'h0) begin
      {i_program_counter_upper_latch, i_stack_top, i_prescaler_on_timer} = seed[23:8];
    end
  end

  initial begin
    for (int i = 0; i < 8192; i++) begin
      seed = lfsr(seed);
      iwd_prog_mem_inst.rom[i] = seed[13:0];
      if (seed[13:8] == 6'h01) iwd_prog_mem_inst.rom[i][7] = 1'b1;
    end
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      fmem[i] = seed[7:0];
    end
    #1 i_rst_n = 1'b0;
    for (int n = 0; n < 2; n++) begin
      repeat (4) @(posedge i_core_clk);
      chk({o_flush_cycle, o_phase, o_file_wr, o_w_reg}, {1'b1, 2'h0, 1'b0, iwd_pkg::W_RST});
      mreset();
      #1 i_rst_n = 1'b1;
      run = 1'b1;
      repeat (8000) @(posedge i_core_clk);
      #1 i_rst_n = 1'b0;
      run = 1'b0;
    end
    finish_test();
  end
endmodule
